// ### core/pbm_pin_mux.sv
// Purpose: Pin multiplexer for port-B pins six to eleven.
// Assumes: Selection settings come from the system integration unit, direction
//          and data from the GPIO port; pad inputs are synchronous to mclk.
// Notes:   Two bits of selection per pin, code zero is general-purpose I/O.
//
// Overview of operation
// - Reset returns all pins to GPIO.
// - GPIO direction set per pin by software.
// - Integration-unit selection routes peripheral functions.
// - Pin six clock input needs clock-mode bit.
// - Pin six: GPIO, serial receive, SDA, clock.
// - Pin seven serial transmit; bidirectional in single-wire.
// - Pin seven SCL; pin eight SCL or CAN.
// - CAN transmit on pin eight is open-drain.
// - Pin nine SDA or CAN receive.
// - Pins ten, eleven: timer B or comparator.
// - I2C lines also reach pins zero, one.
`timescale 1ns/10ps
`default_nettype none
module pbm_pin_mux
    import pbm_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic                    srst,
    input  wire pbm_pkg::pbm_ctrl_t      ctrl_in,
    input  wire pbm_pkg::pbm_periph_out_t periph_out,
    input  wire logic [5:0]              pad_in,
    output var  pbm_pkg::pbm_pad_drive_t pad_drive,
    output var  pbm_pkg::pbm_periph_in_t periph_in,
    output var  logic                    i2c_scl_low_pins_sel,
    output var  logic                    i2c_sda_low_pins_sel
);
    import pbm_pkg::*;

    typedef struct packed {
        pbm_pad_drive_t pad;
        logic           scl_low;
        logic           sda_low;
    } pbm_mux_state_t;

    pbm_mux_state_t state;
    pbm_mux_state_t next_state;
    pbm_ctrl_t      ctrl;

    // Selection is registered so a write lands on all pins together.
    pbm_ctrl_reg u_ctrl (
        .mclk    (mclk),
        .srst    (srst),
        .ctrl_in (ctrl_in),
        .ctrl_q  (ctrl)
    );

    pbm_input_route u_in (
        .mclk      (mclk),
        .srst      (srst),
        .pad_in    (pad_in),
        .ctrl      (ctrl),
        .periph_in (periph_in)
    );

    logic [5:0] alt_out;
    logic [5:0] alt_oe;
    logic [5:0] is_gpio;

    // Per-pin choice: one case per pin so exactly one source is picked.
    always_comb begin
        alt_out = '0;
        alt_oe  = '0;
        unique case (ctrl.func_sel[2*PBM_P6 +: 2])
            PBM_SEL_ALT2: begin
                alt_out[PBM_P6] = 1'b0; // I2C pulls low only.
                alt_oe[PBM_P6]  = periph_out.i2c_sda_oe;
            end
            default: begin
                // Serial receive and clock input are input-only functions.
                alt_out[PBM_P6] = 1'b0;
                alt_oe[PBM_P6]  = 1'b0;
            end
        endcase
        unique case (ctrl.func_sel[2*PBM_P7 +: 2])
            PBM_SEL_ALT1: begin
                alt_out[PBM_P7] = periph_out.serial0_transmit;
                // In single-wire mode the serial unit turns the driver around.
                alt_oe[PBM_P7]  = periph_out.single_wire ? periph_out.serial0_transmit_oe : 1'b1;
            end
            PBM_SEL_ALT2: begin
                alt_out[PBM_P7] = 1'b0;
                alt_oe[PBM_P7]  = periph_out.i2c_scl_oe;
            end
            default: begin
                alt_out[PBM_P7] = 1'b0;
                alt_oe[PBM_P7]  = 1'b0;
            end
        endcase
        unique case (ctrl.func_sel[2*PBM_P8 +: 2])
            PBM_SEL_ALT1: begin
                alt_out[PBM_P8] = 1'b0;
                alt_oe[PBM_P8]  = periph_out.i2c_scl_oe;
            end
            PBM_SEL_ALT2: begin
                // Open drain: drive only a low, release for a high.
                alt_out[PBM_P8] = 1'b0;
                alt_oe[PBM_P8]  = !periph_out.can_transmit_pin;
            end
            default: begin
                alt_out[PBM_P8] = 1'b0;
                alt_oe[PBM_P8]  = 1'b0;
            end
        endcase
        unique case (ctrl.func_sel[2*PBM_P9 +: 2])
            PBM_SEL_ALT1: begin
                alt_out[PBM_P9] = 1'b0;
                alt_oe[PBM_P9]  = periph_out.i2c_sda_oe;
            end
            default: begin
                alt_out[PBM_P9] = 1'b0;
                alt_oe[PBM_P9]  = 1'b0;
            end
        endcase
        unique case (ctrl.func_sel[2*PBM_P10 +: 2])
            PBM_SEL_ALT1: begin
                alt_out[PBM_P10] = periph_out.timer_b_channel0;
                alt_oe[PBM_P10]  = periph_out.timer_b_channel0_oe;
            end
            PBM_SEL_ALT2: begin
                alt_out[PBM_P10] = periph_out.comparator_a_output;
                alt_oe[PBM_P10]  = 1'b1;
            end
            default: begin
                alt_out[PBM_P10] = 1'b0;
                alt_oe[PBM_P10]  = 1'b0;
            end
        endcase
        unique case (ctrl.func_sel[2*PBM_P11 +: 2])
            PBM_SEL_ALT1: begin
                alt_out[PBM_P11] = periph_out.timer_b_channel1;
                alt_oe[PBM_P11]  = periph_out.timer_b_channel1_oe;
            end
            PBM_SEL_ALT2: begin
                alt_out[PBM_P11] = periph_out.comparator_b_output;
                alt_oe[PBM_P11]  = 1'b1;
            end
            default: begin
                alt_out[PBM_P11] = 1'b0;
                alt_oe[PBM_P11]  = 1'b0;
            end
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < PBM_NPINS; g = g + 1) begin : g_pin
            assign is_gpio[g] = (ctrl.func_sel[2*g +: 2] == PBM_SEL_GPIO);
        end
    endgenerate

    always_comb begin
        next_state = state;
        for (int p = 0; p < PBM_NPINS; p++) begin
            // Exactly one of GPIO or the alternate path feeds the pad.
            if (is_gpio[p]) begin
                next_state.pad.out[p] = ctrl.gpio_out[p];
                next_state.pad.oe[p]  = ctrl.gpio_dir[p];
            end else begin
                next_state.pad.out[p] = alt_out[p];
                next_state.pad.oe[p]  = alt_oe[p];
            end
        end
        // The lower I2C pins are released whenever the upper ones carry
        // the bus, so the controller never sees two pins for one line.
        next_state.scl_low = !(ctrl.func_sel[2*PBM_P7 +: 2] == PBM_SEL_ALT2
                               || ctrl.func_sel[2*PBM_P8 +: 2] == PBM_SEL_ALT1);
        next_state.sda_low = !(ctrl.func_sel[2*PBM_P6 +: 2] == PBM_SEL_ALT2
                               || ctrl.func_sel[2*PBM_P9 +: 2] == PBM_SEL_ALT1);
        if (srst) begin
            next_state.pad     = '0;
            next_state.scl_low = 1'b0;
            next_state.sda_low = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        state <= next_state;
    end

    assign pad_drive            = state.pad;
    assign i2c_scl_low_pins_sel = state.scl_low;
    assign i2c_sda_low_pins_sel = state.sda_low;

    sequence s_can_sel;
        ctrl.func_sel[2*PBM_P8 +: 2] == PBM_SEL_ALT2;
    endsequence

    reset_inputs_a: assert property (@(posedge mclk) srst |=> pad_drive.oe == 6'h00)
        else $error("pad driven after reset");
    gpio_dir_a: assert property (@(posedge mclk) disable iff (srst)
        is_gpio[PBM_P10] |=> pad_drive.oe[PBM_P10] == $past(ctrl.gpio_dir[PBM_P10]))
        else $error("gpio direction not followed");
    can_open_a: assert property (@(posedge mclk) disable iff (srst)
        s_can_sel |=> !pad_drive.out[PBM_P8])
        else $error("can pin driven high");
    can_low_a: assert property (@(posedge mclk) disable iff (srst)
        s_can_sel ##0 !periph_out.can_transmit_pin |=> pad_drive.oe[PBM_P8])
        else $error("can low not driven");
    tx_drive_a: assert property (@(posedge mclk) disable iff (srst)
        ctrl.func_sel[2*PBM_P7 +: 2] == PBM_SEL_ALT1 && !periph_out.single_wire
        |=> pad_drive.oe[PBM_P7])
        else $error("transmit not driven");
    cmp_out_a: assert property (@(posedge mclk) disable iff (srst)
        ctrl.func_sel[2*PBM_P11 +: 2] == PBM_SEL_ALT2
        |=> pad_drive.out[PBM_P11] == $past(periph_out.comparator_b_output))
        else $error("comparator b not routed");
    rx_only_a: assert property (@(posedge mclk) disable iff (srst)
        ctrl.func_sel[2*PBM_P6 +: 2] == PBM_SEL_ALT1 |=> !pad_drive.oe[PBM_P6])
        else $error("receive pin driven");
    sda_release_a: assert property (@(posedge mclk) disable iff (srst)
        ctrl.func_sel[2*PBM_P9 +: 2] == PBM_SEL_ALT1 |=> !i2c_sda_low_pins_sel)
        else $error("lower sda pin not released");

    // Each check below looks one edge ahead, since the pad register takes
    // the selection and the peripheral levels of the edge before.
    sequence s_pin6_sda;
        ctrl.func_sel[2*PBM_P6 +: 2] == PBM_SEL_ALT2;
    endsequence

    sequence s_pin7_scl;
        ctrl.func_sel[2*PBM_P7 +: 2] == PBM_SEL_ALT2;
    endsequence

    sequence s_pin8_scl;
        ctrl.func_sel[2*PBM_P8 +: 2] == PBM_SEL_ALT1;
    endsequence

    sequence s_pin9_sda;
        ctrl.func_sel[2*PBM_P9 +: 2] == PBM_SEL_ALT1;
    endsequence

    sequence s_pin10_timer;
        ctrl.func_sel[2*PBM_P10 +: 2] == PBM_SEL_ALT1;
    endsequence

    sequence s_pin11_timer;
        ctrl.func_sel[2*PBM_P11 +: 2] == PBM_SEL_ALT1;
    endsequence

    sequence s_tx_single_wire;
        ctrl.func_sel[2*PBM_P7 +: 2] == PBM_SEL_ALT1 && periph_out.single_wire;
    endsequence

    reset_lines_a: assert property (@(posedge mclk) srst |=> !i2c_scl_low_pins_sel && !i2c_sda_low_pins_sel)
        else $error("lower i2c selects set after reset");
    reset_route_a: assert property (@(posedge mclk) srst |=> periph_in == '0)
        else $error("routed inputs not cleared by reset");

    sda_pin6_a: assert property (@(posedge mclk) disable iff (srst)
        s_pin6_sda |=> pad_drive.oe[PBM_P6] == $past(periph_out.i2c_sda_oe) && !pad_drive.out[PBM_P6])
        else $error("pin six data line not routed");
    clk_pin6_a: assert property (@(posedge mclk) disable iff (srst)
        ctrl.func_sel[2*PBM_P6 +: 2] == PBM_SEL_ALT3 |=> !pad_drive.oe[PBM_P6])
        else $error("clock input pin driven");
    scl_pin7_a: assert property (@(posedge mclk) disable iff (srst)
        s_pin7_scl |=> pad_drive.oe[PBM_P7] == $past(periph_out.i2c_scl_oe) && !pad_drive.out[PBM_P7])
        else $error("pin seven clock line not routed");
    scl_pin8_a: assert property (@(posedge mclk) disable iff (srst)
        s_pin8_scl |=> pad_drive.oe[PBM_P8] == $past(periph_out.i2c_scl_oe) && !pad_drive.out[PBM_P8])
        else $error("pin eight clock line not routed");
    sda_pin9_a: assert property (@(posedge mclk) disable iff (srst)
        s_pin9_sda |=> pad_drive.oe[PBM_P9] == $past(periph_out.i2c_sda_oe) && !pad_drive.out[PBM_P9])
        else $error("pin nine data line not routed");
    can_rx_quiet_a: assert property (@(posedge mclk) disable iff (srst)
        ctrl.func_sel[2*PBM_P9 +: 2] == PBM_SEL_ALT2 |=> !pad_drive.oe[PBM_P9])
        else $error("can receive pin driven");
    can_release_a: assert property (@(posedge mclk) disable iff (srst)
        s_can_sel ##0 periph_out.can_transmit_pin |=> !pad_drive.oe[PBM_P8])
        else $error("can high not released");
    tx_turn_a: assert property (@(posedge mclk) disable iff (srst)
        s_tx_single_wire |=> pad_drive.oe[PBM_P7] == $past(periph_out.serial0_transmit_oe)
        && pad_drive.out[PBM_P7] == $past(periph_out.serial0_transmit))
        else $error("single wire transmit not turned");
    timer_b0_a: assert property (@(posedge mclk) disable iff (srst)
        s_pin10_timer |=> pad_drive.oe[PBM_P10] == $past(periph_out.timer_b_channel0_oe)
        && pad_drive.out[PBM_P10] == $past(periph_out.timer_b_channel0))
        else $error("timer b channel 0 not routed");
    timer_b1_a: assert property (@(posedge mclk) disable iff (srst)
        s_pin11_timer |=> pad_drive.oe[PBM_P11] == $past(periph_out.timer_b_channel1_oe)
        && pad_drive.out[PBM_P11] == $past(periph_out.timer_b_channel1))
        else $error("timer b channel 1 not routed");
    cmp_a_out_a: assert property (@(posedge mclk) disable iff (srst)
        ctrl.func_sel[2*PBM_P10 +: 2] == PBM_SEL_ALT2
        |=> pad_drive.oe[PBM_P10] && pad_drive.out[PBM_P10] == $past(periph_out.comparator_a_output))
        else $error("comparator a not routed");
    unused_code_a: assert property (@(posedge mclk) disable iff (srst)
        ctrl.func_sel[2*PBM_P11 +: 2] == PBM_SEL_ALT3 |=> !pad_drive.oe[PBM_P11])
        else $error("unused code drives pin");
    gpio_data_a: assert property (@(posedge mclk) disable iff (srst)
        is_gpio[PBM_P11] |=> pad_drive.out[PBM_P11] == $past(ctrl.gpio_out[PBM_P11]))
        else $error("gpio data not on pin");
    scl_release_a: assert property (@(posedge mclk) disable iff (srst)
        s_pin8_scl |=> !i2c_scl_low_pins_sel)
        else $error("lower scl pin not released");
    scl_free_a: assert property (@(posedge mclk) disable iff (srst)
        !srst && ctrl.func_sel[2*PBM_P7 +: 2] != PBM_SEL_ALT2 && ctrl.func_sel[2*PBM_P8 +: 2] != PBM_SEL_ALT1
        |=> i2c_scl_low_pins_sel)
        else $error("lower scl pin not offered");
endmodule
`default_nettype wire

// ### core/pbm_pkg.sv
// Purpose: Shared types and constants for the port-B upper pin multiplexer.
// Assumes: One synchronous clock domain; selection codes come from the integration unit.
// Notes:   Six pins, bits 6 to 11 of port B.
package pbm_pkg;

    localparam int PBM_NPINS = 6;

    // Function-select codes per pin; zero is general-purpose I/O.
    localparam logic [1:0] PBM_SEL_GPIO = 2'h0;
    localparam logic [1:0] PBM_SEL_ALT1 = 2'h1;
    localparam logic [1:0] PBM_SEL_ALT2 = 2'h2;
    localparam logic [1:0] PBM_SEL_ALT3 = 2'h3;

    localparam logic [11:0] PBM_SEL_RESET = 12'h000;
    localparam logic [5:0]  PBM_BITS_RESET = 6'h00;

    // Pin slot indices within the group.
    localparam int PBM_P6  = 0;
    localparam int PBM_P7  = 1;
    localparam int PBM_P8  = 2;
    localparam int PBM_P9  = 3;
    localparam int PBM_P10 = 4;
    localparam int PBM_P11 = 5;

    // Pad side of the group: one bit per pin.
    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
    } pbm_pad_drive_t;

    // Settings held by the integration unit and GPIO port.
    typedef struct packed {
        logic [11:0] func_sel;
        logic [5:0]  gpio_dir;
        logic [5:0]  gpio_out;
        logic        clock_source_mode_bit;
    } pbm_ctrl_t;

    // Outputs of the peripherals towards the pads.
    typedef struct packed {
        logic serial0_transmit;
        logic serial0_transmit_oe;
        logic single_wire;
        logic i2c_sda_oe;
        logic i2c_scl_oe;
        logic can_transmit_pin;
        logic timer_b_channel0;
        logic timer_b_channel0_oe;
        logic timer_b_channel1;
        logic timer_b_channel1_oe;
        logic comparator_a_output;
        logic comparator_b_output;
    } pbm_periph_out_t;

    // Pad levels routed back to the peripherals.
    typedef struct packed {
        logic serial0_receive;
        logic i2c_sda_in;
        logic i2c_scl_in;
        logic external_clock_input;
        logic can_receive_pin;
        logic timer_b_channel0_in;
        logic timer_b_channel1_in;
        logic [5:0] gpio_in;
    } pbm_periph_in_t;

endpackage

// ### core/pbm_ctrl_reg.sv
// Purpose: Registers the selection and GPIO settings with the reset defaults.
// Assumes: Synchronous active-high reset.
// Notes:   Reset returns every pin to general-purpose input.
`timescale 1ns/10ps
`default_nettype none
module pbm_ctrl_reg
    import pbm_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire pbm_pkg::pbm_ctrl_t ctrl_in,
    output var  pbm_pkg::pbm_ctrl_t ctrl_q
);
    typedef struct packed {
        pbm_ctrl_t c;
    } pbm_reg_state_t;

    pbm_reg_state_t state;
    pbm_reg_state_t next_state;

    always_comb begin
        next_state   = state;
        next_state.c = ctrl_in;
        if (srst) begin
            next_state.c.func_sel              = PBM_SEL_RESET;
            next_state.c.gpio_dir              = PBM_BITS_RESET;
            next_state.c.gpio_out              = PBM_BITS_RESET;
            next_state.c.clock_source_mode_bit = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        state <= next_state;
    end

    assign ctrl_q = state.c;

    reset_gpio_a: assert property (@(posedge mclk) srst |=> ctrl_q.func_sel == PBM_SEL_RESET)
        else $error("selection not cleared by reset");
endmodule
`default_nettype wire

// ### core/pbm_input_route.sv
// Purpose: Routes pad levels to peripheral inputs by the current selection.
// Assumes: Pad inputs are synchronous to mclk.
// Notes:   An unselected serial, I2C or CAN input reads a quiet high level; clock and timer inputs read low.
`timescale 1ns/10ps
`default_nettype none
module pbm_input_route
    import pbm_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   srst,
    input  wire logic [5:0]             pad_in,
    input  wire pbm_pkg::pbm_ctrl_t     ctrl,
    output var  pbm_pkg::pbm_periph_in_t periph_in
);
    typedef struct packed {
        pbm_periph_in_t r;
    } pbm_in_state_t;

    pbm_in_state_t state;
    pbm_in_state_t next_state;

    function automatic logic [1:0] sel_of(input logic [11:0] s, input int p);
        sel_of = s[2*p +: 2];
    endfunction

    always_comb begin
        logic [11:0] s;
        s = ctrl.func_sel;
        next_state = state;
        next_state.r.gpio_in = pad_in;
        // Idle high keeps I2C and serial receivers quiet when unrouted.
        next_state.r.serial0_receive      = (sel_of(s, PBM_P6) == PBM_SEL_ALT1) ? pad_in[PBM_P6] :
                                            (sel_of(s, PBM_P7) == PBM_SEL_ALT1) ? pad_in[PBM_P7] : 1'b1;
        next_state.r.i2c_sda_in           = (sel_of(s, PBM_P6) == PBM_SEL_ALT2) ? pad_in[PBM_P6] :
                                            (sel_of(s, PBM_P9) == PBM_SEL_ALT1) ? pad_in[PBM_P9] : 1'b1;
        next_state.r.i2c_scl_in           = (sel_of(s, PBM_P7) == PBM_SEL_ALT2) ? pad_in[PBM_P7] :
                                            (sel_of(s, PBM_P8) == PBM_SEL_ALT1) ? pad_in[PBM_P8] : 1'b1;
        next_state.r.external_clock_input = (sel_of(s, PBM_P6) == PBM_SEL_ALT3) && ctrl.clock_source_mode_bit
                                            ? pad_in[PBM_P6] : 1'b0;
        next_state.r.can_receive_pin      = (sel_of(s, PBM_P9) == PBM_SEL_ALT2) ? pad_in[PBM_P9] : 1'b1;
        next_state.r.timer_b_channel0_in  = (sel_of(s, PBM_P10) == PBM_SEL_ALT1) ? pad_in[PBM_P10] : 1'b0;
        next_state.r.timer_b_channel1_in  = (sel_of(s, PBM_P11) == PBM_SEL_ALT1) ? pad_in[PBM_P11] : 1'b0;
        if (srst) begin
            next_state.r = '0;
        end
    end

    always_ff @(posedge mclk) begin
        state <= next_state;
    end

    assign periph_in = state.r;

    external_clock_input_gate_a: assert property (@(posedge mclk) disable iff (srst)
        !ctrl.clock_source_mode_bit |=> !periph_in.external_clock_input)
        else $error("external clock passed without clock mode");
endmodule
`default_nettype wire

// ### dv/pbm_board_model.sv
// Purpose: Board circuitry on the six pads: pull-ups and optional external drivers.
// Assumes: A pad that the chip drives overrides any board driver on it.
// Notes:   A pad that nobody drives rests at the pull-up level.
`timescale 1ns/10ps
`default_nettype none
module pbm_board_model
    import pbm_pkg::*;
(
    input  wire pbm_pkg::pbm_pad_drive_t pad_drive,
    input  wire logic [5:0]              ext_en,
    input  wire logic [5:0]              ext_val,
    output var  logic [5:0]              pad_in
);
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pad_in[i] = pad_drive.oe[i] ? pad_drive.out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule
`default_nettype wire

// ### dv/tb.sv
// Purpose: Self-checking bench for the port-B upper pin multiplexer.
// Assumes: Settling of three edges from a setting change to the routed inputs.
// Notes:   Fields whose value the selection leaves ambiguous are masked.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pbm_pkg::*;
    typedef struct packed {
        pbm_pad_drive_t pd;
        pbm_periph_in_t pi;
        logic [1:0]     lo;
    } pbm_note_t;
    logic            mclk       = 1'b0;
    logic            srst       = 1'b1;
    pbm_ctrl_t       ctrl_in    = '0;
    pbm_periph_out_t periph_out = '0;
    logic [5:0]      ext_en     = 6'h00;
    logic [5:0]      ext_val    = 6'h00;
    logic [5:0]      pad_in;
    pbm_pad_drive_t  pad_drive;
    pbm_periph_in_t  periph_in;
    logic            scl_lo;
    logic            sda_lo;
    logic [15:0]     seed       = 16'h005b;
    pbm_note_t       exp_q[$];
    pbm_note_t       msk_q[$];
    int              n_mismatch = 0;
    int              checks     = 0;
    event            sample_ev;

    always #2.5 mclk = ~mclk;

    pbm_pin_mux dut_u (.mclk(mclk), .srst(srst), .ctrl_in(ctrl_in), .periph_out(periph_out), .pad_in(pad_in),
        .pad_drive(pad_drive), .periph_in(periph_in), .i2c_scl_low_pins_sel(scl_lo), .i2c_sda_low_pins_sel(sda_lo));
    pbm_board_model board_u (.pad_drive(pad_drive), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction

    function automatic void model(input pbm_ctrl_t c, input pbm_periph_out_t p, input logic [5:0] en,
                                  input logic [5:0] v, output pbm_note_t e, output pbm_note_t m);
        logic [1:0] s [6];
        logic [5:0] lv;
        e = '0;
        m = '1;
        e.pd.oe = c.gpio_dir;
        e.pd.out = c.gpio_out;
        for (int i = 0; i < 6; i++) begin
            s[i] = c.func_sel[2*i +: 2];
            if (s[i] != PBM_SEL_GPIO) begin
                e.pd.oe[i] = 1'b0;
                e.pd.out[i] = 1'b0;
            end
        end
        if (s[0] == PBM_SEL_ALT2) e.pd.oe[0] = p.i2c_sda_oe;
        if (s[1] == PBM_SEL_ALT1) begin
            e.pd.oe[1] = p.single_wire ? p.serial0_transmit_oe : 1'b1;
            e.pd.out[1] = p.serial0_transmit;
        end
        if (s[1] == PBM_SEL_ALT2) e.pd.oe[1] = p.i2c_scl_oe;
        if (s[2] == PBM_SEL_ALT1) e.pd.oe[2] = p.i2c_scl_oe;
        if (s[2] == PBM_SEL_ALT2) e.pd.oe[2] = !p.can_transmit_pin;
        if (s[3] == PBM_SEL_ALT1) e.pd.oe[3] = p.i2c_sda_oe;
        if (s[4] == PBM_SEL_ALT1) {e.pd.oe[4], e.pd.out[4]} = {p.timer_b_channel0_oe, p.timer_b_channel0};
        if (s[4] == PBM_SEL_ALT2) {e.pd.oe[4], e.pd.out[4]} = {1'b1, p.comparator_a_output};
        if (s[5] == PBM_SEL_ALT1) {e.pd.oe[5], e.pd.out[5]} = {p.timer_b_channel1_oe, p.timer_b_channel1};
        if (s[5] == PBM_SEL_ALT2) {e.pd.oe[5], e.pd.out[5]} = {1'b1, p.comparator_b_output};
        m.pd.out = e.pd.oe;
        for (int i = 0; i < 6; i++) begin
            lv[i] = e.pd.oe[i] ? e.pd.out[i] : (en[i] ? v[i] : 1'b1);
        end
        e.pi.gpio_in = lv;
        e.pi.serial0_receive = (s[0] == PBM_SEL_ALT1) ? lv[0] : 1'b1;
        // The single-wire receive path on pin seven is the designer's choice, so it is not judged.
        m.pi.serial0_receive = (s[1] != PBM_SEL_ALT1);
        e.pi.i2c_sda_in = (s[0] == PBM_SEL_ALT2) ? lv[0] : ((s[3] == PBM_SEL_ALT1) ? lv[3] : 1'b1);
        m.pi.i2c_sda_in = !(s[0] == PBM_SEL_ALT2 && s[3] == PBM_SEL_ALT1);
        e.pi.i2c_scl_in = (s[1] == PBM_SEL_ALT2) ? lv[1] : ((s[2] == PBM_SEL_ALT1) ? lv[2] : 1'b1);
        m.pi.i2c_scl_in = !(s[1] == PBM_SEL_ALT2 && s[2] == PBM_SEL_ALT1);
        e.pi.external_clock_input = (s[0] == PBM_SEL_ALT3 && c.clock_source_mode_bit) ? lv[0] : 1'b0;
        e.pi.can_receive_pin = (s[3] == PBM_SEL_ALT2) ? lv[3] : 1'b1;
        e.pi.timer_b_channel0_in = (s[4] == PBM_SEL_ALT1) ? lv[4] : 1'b0;
        e.pi.timer_b_channel1_in = (s[5] == PBM_SEL_ALT1) ? lv[5] : 1'b0;
        e.lo = {!(s[1] == PBM_SEL_ALT2 || s[2] == PBM_SEL_ALT1), !(s[0] == PBM_SEL_ALT2 || s[3] == PBM_SEL_ALT1)};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input logic [31:0] msk);
        checks++;
        if (((seen ^ exp) & msk) !== 32'h0000_0000) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic note_zero();
        exp_q.push_back('0);
        msk_q.push_back('1);
        -> sample_ev;
    endtask

    // Settings, peripheral levels and board drivers change together; results are read once settled.
    task automatic apply(input pbm_ctrl_t c);
        pbm_periph_out_t p;
        logic [5:0]      en;
        logic [5:0]      v;
        pbm_note_t       e;
        pbm_note_t       m;
        p = 12'(rnd());
        en = 6'(rnd());
        v = 6'(rnd());
        @(posedge mclk);
        ctrl_in <= c;
        periph_out <= p;
        ext_en <= en;
        ext_val <= v;
        repeat (4) @(posedge mclk);
        #1;
        model(c, p, en, v, e, m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        -> sample_ev;
    endtask

    always @(sample_ev) begin
        pbm_note_t e;
        pbm_note_t m;
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        chk(32'(pad_drive), 32'(e.pd), 32'(m.pd));
        chk(32'(periph_in), 32'(e.pi), 32'(m.pi));
        chk(32'({scl_lo, sda_lo}), 32'(e.lo), 32'(m.lo));
    end

    task automatic give_verdict();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #50000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        pbm_ctrl_t c;
        repeat (4) @(posedge mclk);
        #1;
        note_zero();
        @(posedge mclk);
        srst <= 1'b0;
        $display("test reset done");
        for (int p = 0; p < 6; p++) begin
            for (int code = 0; code < 4; code++) begin
                for (int md = 0; md < 2; md++) begin
                    c = 25'({rnd(), rnd()});
                    c.func_sel = 12'h000;
                    c.func_sel[2*p +: 2] = 2'(code);
                    c.clock_source_mode_bit = md[0];
                    apply(c);
                end
            end
        end
        $display("test every code done");
        for (int k = 0; k < 150; k++) begin
            apply(25'({rnd(), rnd()}));
        end
        $display("test random mix done");
        apply(25'({rnd(), rnd()}));
        @(posedge mclk);
        srst <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        note_zero();
        @(posedge mclk);
        srst <= 1'b0;
        apply(25'({rnd(), rnd()}));
        $display("test second reset done");
        @(posedge mclk);
        give_verdict();
    end
endmodule
`default_nettype wire
